// [mrl_pkg.sv]
package mrl_pkg;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam logic [7:0] REG_REACTION = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;
  localparam logic [7:0] REG_LIM_MIN = 8'h0c;
  localparam logic [7:0] REG_LIM_MAX = 8'h10;
  localparam logic [7:0] REG_TARGET = 8'h14;
  localparam logic [7:0] REG_TARGET_OUT = 8'h18;
  localparam logic [7:0] REG_SPEED_NUM = 8'h1c;
  localparam logic [7:0] REG_SPEED_DEN = 8'h20;
  localparam logic [7:0] REG_ACCEL_NUM = 8'h24;
  localparam logic [7:0] REG_ACCEL_DEN = 8'h28;
  localparam logic [7:0] REG_JERK_NUM = 8'h2c;
  localparam logic [7:0] REG_JERK_DEN = 8'h30;
  localparam logic [7:0] REG_SPEED_UNIT = 8'h34;
  localparam logic [7:0] REG_VELMODE_DIM = 8'h38;
  localparam logic [7:0] REG_LIMIT_POS = 8'h3c;

  // ----------------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------------
  localparam int STAT_WARNING_BIT = 7;
  localparam int CTRL_QUICKSTOP_BIT = 2;
  localparam int CTRL_VELMODE_BIT = 16;
  localparam logic [31:0] SPEED_UNIT_RPM = 32'h00b44700;
  localparam int UNIT_TIME_LSB = 8;
  localparam int UNIT_POS_LSB = 16;
  localparam int UNIT_EXP_LSB = 24;
  localparam logic [31:0] FACTOR_ONE = 32'h00000001;

  // Reaction codes, signed.
  localparam logic signed [7:0] REACT_DISCARD = -8'sd2;
  localparam logic signed [7:0] REACT_NOTE = -8'sd1;
  localparam logic signed [7:0] REACT_OFF = 8'sd0;
  localparam logic signed [7:0] REACT_SLOW_DIS = 8'sd1;
  localparam logic signed [7:0] REACT_QUICK_DIS = 8'sd2;
  localparam logic signed [7:0] REACT_SLOW_QSA = 8'sd5;
  localparam logic signed [7:0] REACT_QUICK_QSA = 8'sd6;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int APP_PERIOD_US = 1000;
  localparam int CUR_PERIOD_NS = 62500;
  localparam int VEL_PERIOD_US = 250;
  localparam int APP_CYCLES = CLK_HZ / 1_000_000 * APP_PERIOD_US;
  localparam int CUR_CYCLES = CLK_HZ / 1_000_000 * CUR_PERIOD_NS / 1000;
  localparam int VEL_CYCLES = CLK_HZ / 1_000_000 * VEL_PERIOD_US;

  typedef enum logic [4:0] {
    MRL_RUN = 5'b00001,
    MRL_RAMP_DIS = 5'b00010,
    MRL_RAMP_QSA = 5'b00100,
    MRL_DISABLED = 5'b01000,
    MRL_QSA = 5'b10000
  } mrl_state_e;

  // Drive command toward the power state machine.
  typedef struct packed {
    logic power_off;
    logic ramp_slow;
    logic ramp_quick;
    logic go_disabled;
    logic go_qsa;
    logic go_enabled;
  } mrl_drive_s;

  typedef struct packed {
    logic low;
    logic high;
  } mrl_switch_s;

endpackage : mrl_pkg

// [mrl_tick.sv]
`timescale 1ns/10ps
// One-cycle enable pulse every PERIOD clocks.
module mrl_tick #(
  parameter int PERIOD = 40000
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic tick
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_tick;

  always_comb begin
    next_tick = (count == 32'(PERIOD - 1));
    next_count = next_tick ? 32'h00000000 : count + 32'h00000001;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule : mrl_tick

// [mrl_clamp.sv]
`timescale 1ns/10ps
// Clamps a target to the soft limits; outside the range only moves toward it pass.
module mrl_clamp (
  input wire logic signed [31:0] target,
  input wire logic signed [31:0] actual,
  input wire logic signed [31:0] lim_min,
  input wire logic signed [31:0] lim_max,
  output logic signed [31:0] result,
  output logic accept
);
  always_comb begin
    result = target;
    if (target < lim_min) begin
      result = lim_min;
    end else if (target > lim_max) begin
      result = lim_max;
    end
    accept = 1'b1;
    if (actual < lim_min) begin
      accept = (target > actual);
    end else if (actual > lim_max) begin
      accept = (target < actual);
    end
  end
endmodule : mrl_clamp

// [mrl_limiter.sv]
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
// Functional notes
// - Switch trigger stores position, sets warning, reacts
// - Reaction -2: no action, discard stored position
// - Reaction -1 default: no action, keep position
// - Reaction 0: power off, go switch-on-disabled
// - Reactions 1/2: slow/quick ramp, then disabled
// - Reactions 5/6: ramp, then energized quick-stop-active
// - Except -1/-2 block motion past switch
// - Warning clears per reaction and position rule
// - Leave quick-stop-active only on quickstop rising; a new trigger under 0/1/2/5/6 also leaves it
// - Targets clamped to soft position limits
// - Outside range, only moves toward range accepted
// - Inputs processed once per 1 ms tick
// - Current 62.5us, velocity 250us, position 1ms ticks
// - Speed factor is numerator over denominator
// - Acceleration factor is numerator over denominator
// - Jerk factor is numerator over denominator
// - Speed unit word resets to rpm code
// - Velocity mode forces rpm speed unit
// - Speed unit fields: time, position, exponent
module mrl_limiter #(
  parameter int APP_CYCLES = mrl_pkg::APP_CYCLES,
  parameter int CUR_CYCLES = mrl_pkg::CUR_CYCLES,
  parameter int VEL_CYCLES = mrl_pkg::VEL_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Motion side
  input wire mrl_pkg::mrl_switch_s limit_switch,
  input wire logic signed [31:0] actual_position,
  input wire logic ramp_done,
  // Drive outputs
  output mrl_pkg::mrl_drive_s drive_cmd,
  output mrl_pkg::mrl_switch_s motion_block,
  output logic [31:0] target_position_value,
  output logic target_valid,
  output logic cur_tick,
  output logic vel_tick,
  output logic app_tick
);

  // ----------------------------------------------------------------------------
  // Rate ticks
  // ----------------------------------------------------------------------------
  logic app_en;
  logic cur_en;
  logic vel_en;

  mrl_tick #(.PERIOD(APP_CYCLES)) u_app (.clk(clk), .reset_n(reset_n), .tick(app_en));
  mrl_tick #(.PERIOD(CUR_CYCLES)) u_cur (.clk(clk), .reset_n(reset_n), .tick(cur_en));
  mrl_tick #(.PERIOD(VEL_CYCLES)) u_vel (.clk(clk), .reset_n(reset_n), .tick(vel_en));

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic signed [7:0] reaction, next_reaction;
  logic [31:0] control, next_control;
  logic signed [31:0] lim_min, next_lim_min;
  logic signed [31:0] lim_max, next_lim_max;
  logic signed [31:0] target_req, next_target_req;
  logic target_pend, next_target_pend;
  logic [31:0] speed_num, next_speed_num, speed_den, next_speed_den;
  logic [31:0] accel_num, next_accel_num, accel_den, next_accel_den;
  logic [31:0] jerk_num, next_jerk_num, jerk_den, next_jerk_den;
  logic [31:0] speed_unit, next_speed_unit;
  logic [31:0] velmode_dim, next_velmode_dim;
  logic [31:0] next_rdata;

  function automatic logic react_valid(input logic signed [7:0] code);
    react_valid = (code == mrl_pkg::REACT_DISCARD) || (code == mrl_pkg::REACT_NOTE) ||
      (code == mrl_pkg::REACT_OFF) || (code == mrl_pkg::REACT_SLOW_DIS) ||
      (code == mrl_pkg::REACT_QUICK_DIS) || (code == mrl_pkg::REACT_SLOW_QSA) ||
      (code == mrl_pkg::REACT_QUICK_QSA);
  endfunction : react_valid

  function automatic logic [31:0] nz(input logic [31:0] v);
    nz = (v == 32'h00000000) ? mrl_pkg::FACTOR_ONE : v;
  endfunction : nz

  // Velocity mode reports rpm regardless of the stored word.
  logic [31:0] speed_unit_view;
  assign speed_unit_view = control[mrl_pkg::CTRL_VELMODE_BIT] ?
    mrl_pkg::SPEED_UNIT_RPM : speed_unit;

  // Limiter state declared ahead of readback.
  mrl_pkg::mrl_state_e state, next_state;
  logic warning, next_warning;
  logic signed [31:0] limit_pos, next_limit_pos;
  logic pos_valid, next_pos_valid;
  mrl_pkg::mrl_switch_s hit_side, next_hit_side;

  always_comb begin
    next_reaction = reaction;
    next_control = control;
    next_lim_min = lim_min;
    next_lim_max = lim_max;
    next_target_req = target_req;
    next_target_pend = target_pend & ~app_en;
    next_speed_num = speed_num;
    next_speed_den = speed_den;
    next_accel_num = accel_num;
    next_accel_den = accel_den;
    next_jerk_num = jerk_num;
    next_jerk_den = jerk_den;
    next_speed_unit = speed_unit;
    next_velmode_dim = velmode_dim;
    next_rdata = 32'h00000000;
    if (wr) begin
      case (addr)
        mrl_pkg::REG_REACTION: begin
          if (react_valid(wdata[7:0])) begin
            next_reaction = wdata[7:0];
          end
        end
        mrl_pkg::REG_CONTROL: next_control = wdata;
        mrl_pkg::REG_LIM_MIN: next_lim_min = wdata;
        mrl_pkg::REG_LIM_MAX: next_lim_max = wdata;
        mrl_pkg::REG_TARGET: begin
          next_target_req = wdata;
          next_target_pend = 1'b1;
        end
        mrl_pkg::REG_SPEED_NUM: next_speed_num = wdata;
        mrl_pkg::REG_SPEED_DEN: next_speed_den = nz(wdata);
        mrl_pkg::REG_ACCEL_NUM: next_accel_num = wdata;
        mrl_pkg::REG_ACCEL_DEN: next_accel_den = nz(wdata);
        mrl_pkg::REG_JERK_NUM: next_jerk_num = wdata;
        mrl_pkg::REG_JERK_DEN: next_jerk_den = nz(wdata);
        mrl_pkg::REG_SPEED_UNIT: next_speed_unit = wdata;
        mrl_pkg::REG_VELMODE_DIM: next_velmode_dim = wdata;
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        mrl_pkg::REG_REACTION: next_rdata = {{24{reaction[7]}}, reaction};
        mrl_pkg::REG_STATUS: next_rdata = {17'h0, pos_valid, state, 1'b0, warning, 3'h0,
          hit_side, 2'h0};
        mrl_pkg::REG_CONTROL: next_rdata = control;
        mrl_pkg::REG_LIM_MIN: next_rdata = lim_min;
        mrl_pkg::REG_LIM_MAX: next_rdata = lim_max;
        mrl_pkg::REG_TARGET: next_rdata = target_req;
        mrl_pkg::REG_TARGET_OUT: next_rdata = target_position_value;
        mrl_pkg::REG_SPEED_NUM: next_rdata = speed_num;
        mrl_pkg::REG_SPEED_DEN: next_rdata = speed_den;
        mrl_pkg::REG_ACCEL_NUM: next_rdata = accel_num;
        mrl_pkg::REG_ACCEL_DEN: next_rdata = accel_den;
        mrl_pkg::REG_JERK_NUM: next_rdata = jerk_num;
        mrl_pkg::REG_JERK_DEN: next_rdata = jerk_den;
        mrl_pkg::REG_SPEED_UNIT: next_rdata = speed_unit_view;
        mrl_pkg::REG_VELMODE_DIM: next_rdata = velmode_dim;
        mrl_pkg::REG_LIMIT_POS: next_rdata = limit_pos;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reaction <= mrl_pkg::REACT_NOTE;
      control <= 32'h00000000;
      lim_min <= 32'h80000000;
      lim_max <= 32'h7fffffff;
      target_req <= 32'h00000000;
      target_pend <= 1'b0;
      speed_num <= mrl_pkg::FACTOR_ONE;
      speed_den <= mrl_pkg::FACTOR_ONE;
      accel_num <= mrl_pkg::FACTOR_ONE;
      accel_den <= mrl_pkg::FACTOR_ONE;
      jerk_num <= mrl_pkg::FACTOR_ONE;
      jerk_den <= mrl_pkg::FACTOR_ONE;
      speed_unit <= mrl_pkg::SPEED_UNIT_RPM;
      velmode_dim <= mrl_pkg::FACTOR_ONE;
      rdata <= 32'h00000000;
    end else begin
      reaction <= next_reaction;
      control <= next_control;
      lim_min <= next_lim_min;
      lim_max <= next_lim_max;
      target_req <= next_target_req;
      target_pend <= next_target_pend;
      speed_num <= next_speed_num;
      speed_den <= next_speed_den;
      accel_num <= next_accel_num;
      accel_den <= next_accel_den;
      jerk_num <= next_jerk_num;
      jerk_den <= next_jerk_den;
      speed_unit <= next_speed_unit;
      velmode_dim <= next_velmode_dim;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // Limit-switch reaction
  // ----------------------------------------------------------------------------
  // Inputs are only looked at on the application tick, so a pulse shorter than
  // one tick can be missed; this matches the drive's sampling of digital inputs.
  mrl_pkg::mrl_switch_s sw_prev, next_sw_prev;
  logic qs_prev, next_qs_prev;
  mrl_pkg::mrl_drive_s next_drive_cmd;
  mrl_pkg::mrl_switch_s next_motion_block;
  logic qs_now;
  logic any_sw;
  logic trig;
  logic moved_back;

  assign qs_now = control[mrl_pkg::CTRL_QUICKSTOP_BIT];
  assign any_sw = limit_switch.low | limit_switch.high;
  assign trig = (limit_switch.low & ~sw_prev.low) | (limit_switch.high & ~sw_prev.high);
  assign moved_back = !pos_valid ||
    (hit_side.high && actual_position < limit_pos) ||
    (hit_side.low && actual_position > limit_pos);

  always_comb begin
    next_state = state;
    next_warning = warning;
    next_limit_pos = limit_pos;
    next_pos_valid = pos_valid;
    next_hit_side = hit_side;
    next_sw_prev = sw_prev;
    next_qs_prev = qs_prev;
    next_drive_cmd = '0;
    next_motion_block = motion_block;
    if (reaction == mrl_pkg::REACT_DISCARD) begin
      next_pos_valid = 1'b0;
    end
    if (app_en) begin
      next_sw_prev = limit_switch;
      next_qs_prev = qs_now;
      if (trig) begin
        next_warning = 1'b1;
        next_hit_side = limit_switch;
        next_limit_pos = actual_position;
        next_pos_valid = (reaction != mrl_pkg::REACT_DISCARD);
        case (reaction)
          mrl_pkg::REACT_OFF: begin
            next_drive_cmd.power_off = 1'b1;
            next_drive_cmd.go_disabled = 1'b1;
            next_state = mrl_pkg::MRL_DISABLED;
          end
          mrl_pkg::REACT_SLOW_DIS: begin
            next_drive_cmd.ramp_slow = 1'b1;
            next_state = mrl_pkg::MRL_RAMP_DIS;
          end
          mrl_pkg::REACT_QUICK_DIS: begin
            next_drive_cmd.ramp_quick = 1'b1;
            next_state = mrl_pkg::MRL_RAMP_DIS;
          end
          mrl_pkg::REACT_SLOW_QSA: begin
            next_drive_cmd.ramp_slow = 1'b1;
            next_state = mrl_pkg::MRL_RAMP_QSA;
          end
          mrl_pkg::REACT_QUICK_QSA: begin
            next_drive_cmd.ramp_quick = 1'b1;
            next_state = mrl_pkg::MRL_RAMP_QSA;
          end
          default: ;
        endcase
      end else if (warning && !any_sw) begin
        if (reaction == mrl_pkg::REACT_DISCARD || moved_back) begin
          next_warning = 1'b0;
        end
      end
      // Block travel beyond an active switch unless reaction is -1 or -2.
      if (reaction == mrl_pkg::REACT_NOTE || reaction == mrl_pkg::REACT_DISCARD) begin
        next_motion_block = '0;
      end else begin
        next_motion_block = limit_switch;
      end
      case (state)
        mrl_pkg::MRL_RUN: ;
        mrl_pkg::MRL_RAMP_DIS: begin
          if (ramp_done) begin
            next_drive_cmd.go_disabled = 1'b1;
            next_state = mrl_pkg::MRL_DISABLED;
          end
        end
        mrl_pkg::MRL_RAMP_QSA: begin
          if (ramp_done) begin
            next_drive_cmd.go_qsa = 1'b1;
            next_state = mrl_pkg::MRL_QSA;
          end
        end
        mrl_pkg::MRL_DISABLED: begin
          if (!trig && qs_now && !qs_prev) begin
            next_state = mrl_pkg::MRL_RUN;
          end
        end
        mrl_pkg::MRL_QSA: begin
          if (qs_now && !qs_prev) begin
            next_drive_cmd.go_enabled = 1'b1;
            next_state = mrl_pkg::MRL_RUN;
          end
        end
        default: next_state = mrl_pkg::MRL_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= mrl_pkg::MRL_RUN;
      warning <= 1'b0;
      limit_pos <= 32'h00000000;
      pos_valid <= 1'b0;
      hit_side <= '0;
      sw_prev <= '0;
      qs_prev <= 1'b0;
      drive_cmd <= '0;
      motion_block <= '0;
    end else begin
      state <= next_state;
      warning <= next_warning;
      limit_pos <= next_limit_pos;
      pos_valid <= next_pos_valid;
      hit_side <= next_hit_side;
      sw_prev <= next_sw_prev;
      qs_prev <= next_qs_prev;
      drive_cmd <= next_drive_cmd;
      motion_block <= next_motion_block;
    end
  end

  // ----------------------------------------------------------------------------
  // Target clamp and rate outputs
  // ----------------------------------------------------------------------------
  logic signed [31:0] clamped;
  logic accepted;
  logic [31:0] next_target_out;
  logic next_target_valid;

  mrl_clamp u_clamp (
    .target(target_req),
    .actual(actual_position),
    .lim_min(lim_min),
    .lim_max(lim_max),
    .result(clamped),
    .accept(accepted)
  );

  always_comb begin
    next_target_out = target_position_value;
    next_target_valid = 1'b0;
    if (app_en && target_pend && accepted) begin
      next_target_out = clamped;
      next_target_valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      target_position_value <= 32'h00000000;
      target_valid <= 1'b0;
      app_tick <= 1'b0;
      cur_tick <= 1'b0;
      vel_tick <= 1'b0;
    end else begin
      target_position_value <= next_target_out;
      target_valid <= next_target_valid;
      app_tick <= app_en;
      cur_tick <= cur_en;
      vel_tick <= vel_en;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  trig_sets_warn_a: assert property (@(posedge clk) disable iff (!reset_n)
    app_en && trig |=> warning) else $error("warning not set on trigger");
  discard_pos_a: assert property (@(posedge clk) disable iff (!reset_n)
    reaction == mrl_pkg::REACT_DISCARD |=> !pos_valid) else $error("position kept");
  note_no_act_a: assert property (@(posedge clk) disable iff (!reset_n)
    app_en && trig && reaction == mrl_pkg::REACT_NOTE |=> drive_cmd == '0)
    else $error("action on note-only");
  off_now_a: assert property (@(posedge clk) disable iff (!reset_n)
    app_en && trig && reaction == mrl_pkg::REACT_OFF |=> drive_cmd.power_off &&
    state == mrl_pkg::MRL_DISABLED) else $error("power stage not cut");
  quick_ramp_a: assert property (@(posedge clk) disable iff (!reset_n)
    app_en && trig && reaction == mrl_pkg::REACT_QUICK_DIS |=> drive_cmd.ramp_quick)
    else $error("no quick ramp");
  qsa_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
    state == mrl_pkg::MRL_RAMP_QSA && app_en && ramp_done && !trig |=>
    state == mrl_pkg::MRL_QSA) else $error("quick-stop-active not entered");
  block_none_a: assert property (@(posedge clk) disable iff (!reset_n)
    app_en && reaction == mrl_pkg::REACT_NOTE |=> motion_block == '0)
    else $error("blocked at note-only");
  qsa_exit_a: assert property (@(posedge clk) disable iff (!reset_n)
    state == mrl_pkg::MRL_QSA && !(app_en && qs_now && !qs_prev) |=>
    state == mrl_pkg::MRL_QSA) else $error("left quick-stop-active early");
  clamp_out_a: assert property (@(posedge clk) disable iff (!reset_n)
    target_valid |-> $signed(target_position_value) <= lim_max ||
    $changed(lim_max)) else $error("target above limit");

endmodule : mrl_limiter

// [mrl_drive_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Drive state machine stand-in
// ----------------------------------------------------------------------------
// A slow ramp takes longer than a quick one, so both answer speeds are seen.
module mrl_drive_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Command in, ramp status out
  input wire mrl_pkg::mrl_drive_s drive_cmd,
  output logic ramp_done
);
  logic [3:0] count;
  always_ff @(posedge clk) begin
    if (!reset_n || drive_cmd.go_disabled || drive_cmd.go_qsa) begin
      count <= 4'h0;
      ramp_done <= 1'b0;
    end else if (drive_cmd.ramp_slow) begin
      count <= 4'h9;
    end else if (drive_cmd.ramp_quick) begin
      count <= 4'h2;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
      ramp_done <= (count == 4'h1);
    end
  end
endmodule : mrl_drive_model

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  mrl_pkg::mrl_switch_s limit_switch = 2'b00;
  logic signed [31:0] actual_position = 32'sh00000000;
  logic ramp_done;
  mrl_pkg::mrl_drive_s drive_cmd;
  mrl_pkg::mrl_switch_s motion_block;
  logic [31:0] target_position_value;
  logic target_valid, cur_tick, vel_tick, app_tick;
  logic [2:0] ticks;
  logic [31:0] rv;
  int n_errors = 0;
  int comparisons = 0;

  assign ticks = {app_tick, vel_tick, cur_tick};
  always #12.5 clk = ~clk;

  mrl_limiter #(.APP_CYCLES(40), .CUR_CYCLES(8), .VEL_CYCLES(16)) dut_u (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .limit_switch(limit_switch), .actual_position(actual_position),
    .ramp_done(ramp_done), .drive_cmd(drive_cmd), .motion_block(motion_block),
    .target_position_value(target_position_value), .target_valid(target_valid),
    .cur_tick(cur_tick), .vel_tick(vel_tick), .app_tick(app_tick));
  mrl_drive_model model_u (.clk(clk), .reset_n(reset_n), .drive_cmd(drive_cmd),
    .ramp_done(ramp_done));

  // ----------------------------------------------------------------------------
  // Bus and checks
  // ----------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic wait_app(input int n);
    repeat (n * 40) @(posedge clk);
  endtask : wait_app

  task automatic wait_cmd(input int b);
    logic seen;
    seen = 1'b0;
    repeat (200) begin
      @(posedge clk);
      #1;
      if (drive_cmd[b] === 1'b1) seen = 1'b1;
      if (seen) break;
    end
    check("drive command", {31'h0, seen}, 32'h1);
  endtask : wait_cmd

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic test_defaults();
    reg_rd(mrl_pkg::REG_REACTION, rv);
    check("reaction", rv, 32'hffffffff);
    reg_rd(mrl_pkg::REG_SPEED_UNIT, rv);
    check("speed unit", rv, mrl_pkg::SPEED_UNIT_RPM);
    reg_rd(mrl_pkg::REG_SPEED_NUM, rv);
    check("speed num", rv, 32'h1);
    reg_rd(mrl_pkg::REG_ACCEL_DEN, rv);
    check("accel den", rv, 32'h1);
    reg_rd(mrl_pkg::REG_JERK_NUM, rv);
    check("jerk num", rv, 32'h1);
    reg_rd(8'h40, rv);
    check("unmapped", rv, 32'h0);
    reg_wr(mrl_pkg::REG_REACTION, 32'h3);
    reg_rd(mrl_pkg::REG_REACTION, rv);
    check("bad reaction", rv, 32'hffffffff);
    reg_wr(mrl_pkg::REG_SPEED_DEN, 32'h0);
    reg_rd(mrl_pkg::REG_SPEED_DEN, rv);
    check("zero den", rv, 32'h1);
    reg_wr(mrl_pkg::REG_SPEED_UNIT, 32'hfd010300);
    reg_rd(mrl_pkg::REG_SPEED_UNIT, rv);
    check("unit word", rv, 32'hfd010300);
    reg_wr(mrl_pkg::REG_CONTROL, 32'h00010004);
    reg_rd(mrl_pkg::REG_SPEED_UNIT, rv);
    check("velocity unit", rv, mrl_pkg::SPEED_UNIT_RPM);
    reg_wr(mrl_pkg::REG_CONTROL, 32'h4);
  endtask : test_defaults

  task automatic tick_case(input int idx, input int period);
    int n;
    n = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      if (ticks[idx] === 1'b1) break;
    end
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ticks[idx] !== 1'b1 && n < 100);
    check("tick period", n, period);
  endtask : tick_case

  task automatic test_switch();
    logic signed [7:0] codes [7] = '{-8'sd2, -8'sd1, 8'sd0, 8'sd1, 8'sd2, 8'sd5, 8'sd6};
    int cmd_bit [7] = '{0, 0, 5, 4, 3, 4, 3};
    logic [4:0] state_exp [7] = '{5'h01, 5'h01, 5'h08, 5'h08, 5'h08, 5'h10, 5'h10};
    for (int i = 0; i < 7; i++) begin
      reg_wr(mrl_pkg::REG_REACTION, 32'(codes[i]));
      wait_app(2);
      limit_switch <= 2'b01;
      if (codes[i] >= 0) begin
        wait_cmd(cmd_bit[i]);
        check("block", motion_block, 2'b01);
        if (codes[i] > 8'sd0) wait_cmd(codes[i] > 8'sd2 ? 1 : 2);
      end
      wait_app(3);
      reg_rd(mrl_pkg::REG_STATUS, rv);
      check("warning", rv[7], 1'b1);
      check("state", rv[13:9], state_exp[i]);
      if (codes[i] < 0) begin
        check("free", motion_block, 2'b00);
        check("position kept", rv[14], codes[i] == -8'sd1);
      end
      // Quick-stop bit to 0 first, then back to 1; the rising edge returns the limiter to run.
      reg_wr(mrl_pkg::REG_CONTROL, 32'h0);
      wait_app(2);
      reg_wr(mrl_pkg::REG_CONTROL, 32'h4);
      if (codes[i] > 8'sd4) wait_cmd(0);
      wait_app(2);
      reg_wr(mrl_pkg::REG_REACTION, 32'hfffffffe);
      limit_switch <= 2'b00;
      wait_app(3);
      reg_rd(mrl_pkg::REG_STATUS, rv);
      check("warning clear", rv[7], 1'b0);
      check("back to run", rv[13:9], 5'h01);
    end
    // A switch blip shorter than one application cycle goes unseen.
    reg_wr(mrl_pkg::REG_REACTION, 32'hffffffff);
    tick_case(2, 40);
    repeat (3) @(posedge clk);
    limit_switch <= 2'b01;
    repeat (5) @(posedge clk);
    limit_switch <= 2'b00;
    wait_app(2);
    reg_rd(mrl_pkg::REG_STATUS, rv);
    check("blip unseen", rv[7], 1'b0);
    // Under -1 the warning waits for travel back past the noted position.
    @(posedge clk);
    actual_position <= 32'sd50;
    limit_switch <= 2'b01;
    wait_app(2);
    limit_switch <= 2'b00;
    wait_app(2);
    reg_rd(mrl_pkg::REG_LIMIT_POS, rv);
    check("noted position", rv, 32'd50);
    reg_rd(mrl_pkg::REG_STATUS, rv);
    check("warning held", rv[7], 1'b1);
    @(posedge clk);
    actual_position <= 32'sd49;
    wait_app(2);
    reg_rd(mrl_pkg::REG_STATUS, rv);
    check("warning moved back", rv[7], 1'b0);
  endtask : test_switch

  task automatic target_case(input logic [31:0] pos, tgt, input logic ok, input logic [31:0] exp);
    logic seen;
    seen = 1'b0;
    reg_wr(mrl_pkg::REG_TARGET, tgt);
    actual_position <= pos;
    repeat (100) begin
      @(posedge clk);
      #1;
      if (target_valid === 1'b1) seen = 1'b1;
    end
    check("target accepted", seen, ok);
    if (ok) check("target value", target_position_value, exp);
  endtask : target_case

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    test_defaults();
    tick_case(0, 8);
    tick_case(1, 16);
    test_switch();
    reg_wr(mrl_pkg::REG_LIM_MIN, -32'sd100);
    reg_wr(mrl_pkg::REG_LIM_MAX, 32'sd100);
    target_case(0, 500, 1'b1, 100);
    target_case(0, -500, 1'b1, -100);
    target_case(0, 42, 1'b1, 42);
    target_case(300, 200, 1'b1, 100);
    target_case(300, 400, 1'b0, 0);
    target_case(-300, -400, 1'b0, 0);
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule : testbench
